// File: bench/ccel_asserts.sv
// Checker: port properties of the comparator event block
`timescale 1ns/1ps
`default_nettype none
module ccel_asserts
  import ccel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic analog_compare,
  input wire logic comparator_output_pin,
  input wire logic opamp_on,
  input wire logic comparator_on,
  input wire logic event_trigger
);
  logic [15:0] sh;
  logic [2:0] age;
  logic blk;
  wire logic ac = analog_compare;
  wire logic wr = psel && penable && pwrite && paddr == CCEL_ADDR_CTRL;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Age guards the checks against a control word still settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sh, age, blk} <= '0;
    end else begin
      sh <= wr && pready ? pwdata[15:0] : sh;
      age <= wr && pready ? 3'h0 : age + 3'(age != 3'h7);
      // A clear on the same edge as a late trigger still re-arms
      blk <= (event_trigger || blk) && !(wr && !pready && !pwdata[9]);
    end
  end
  sequence s_wr; wr && pready; endsequence
  property p_op; s_wr |=> opamp_on == $past(pwdata[10]); endproperty
  a_op: assert property (p_op) else $error("op amp");
  property p_en; s_wr |=> comparator_on == $past(pwdata[15]); endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_blk; blk |-> !event_trigger; endproperty
  a_blk: assert property (p_blk) else $error("not held");
  property p_pin0; age > 3'h2 && !sh[14] |-> !comparator_output_pin; endproperty
  a_pin0: assert property (p_pin0) else $error("pin on");
  property p_pin; age > 3'h3 && sh[15:14] == 2'h3 |->
    comparator_output_pin == ($past(ac, 2) ^ sh[13]); endproperty
  a_pin: assert property (p_pin) else $error("pin level");
  property p_chg; event_trigger && age > 3'h4 |-> $past(ac, 2) != $past(ac, 3); endproperty
  a_chg: assert property (p_chg) else $error("no change");
  property p_off; age > 3'h4 && sh[7:6] == 2'h0 |-> !event_trigger; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_up; event_trigger && age > 3'h4 && sh[7:6] == 2'h1 |-> $past(ac, 2) ^ sh[13]; endproperty
  a_up: assert property (p_up) else $error("rise");
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Testbench: APB stimulus and edge model for the comparator event block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_top
  import ccel_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, analog_compare = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, comparator_output_pin, opamp_on, comparator_on;
  logic event_trigger, irq, pos_ref_select;
  logic [1:0] neg_input_select;
  int fails = 0, samples_checked = 0, seed = 56326, t, c, n, i, m, k, ev, p;
  ccel_top u_dut (.*);
  initial forever #25 pclk = ~pclk;
  task automatic results();
    $display("%0d checks, %0d fails", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 9 && pready !== 1'b1; t++) @(posedge pclk);
    if (pready !== 1'b1) begin
      fails++;
      results();
    end
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h010, 0);
    `CHK({er, rd}, 33'h100000000) // unmapped
    for (k = 0; k < 4; k++) begin
      m = $random(seed) & 1;
      i = $random(seed) & 1;
      c = 32'hC400 | k << 6 | i << 13 | $random(seed) & 32'h13;
      // Adjusted level starts low so enabling makes no edge
      analog_compare <= i[0];
      apb(1, 12'h00C, 0);
      apb(1, 12'h000, 0);
      apb(1, 12'h000, c);
      apb(0, 12'h008, 0);
      apb(1, 12'h00C, m);
      `CHK({comparator_on, opamp_on, neg_input_select, pos_ref_select}, {2'h3, c[1:0], c[4]})
      ev = 0;
      p = 0;
      repeat (6) begin
        analog_compare <= $random(seed);
        repeat (5) @(posedge pclk);
        n = analog_compare ^ i;
        if (!ev && (k == 3 && n != p || k == 1 && n > p || k == 2 && n < p)) ev = 1;
        p = n;
        `CHK(comparator_output_pin, n[0])
        apb(0, 12'h004, 0);
        `CHK(rd, 32'(ev << 8 | n))
      end
      apb(0, 12'h000, 0);
      `CHK(rd, 32'(c | ev << 9 | n << 8))
      `CHK(irq, 1'(ev & m))
      apb(0, 12'h008, 0);
      `CHK(rd, 32'(ev))
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      $display("edge mode %0d done", k);
    end
    results();
  end
endmodule
bind ccel_top ccel_asserts u_chk (.*);
`default_nettype wire

// File: inc/ccel_pkg.sv
// Package: register map, field positions and reset values for the comparator event block
package ccel_pkg;
  localparam logic [11:0] CCEL_ADDR_CTRL = 12'h000;
  localparam logic [11:0] CCEL_ADDR_STAT = 12'h004;
  localparam logic [11:0] CCEL_ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] CCEL_ADDR_IRQ_MASK = 12'h00C;

  localparam int CCEL_BIT_ENABLE = 15;
  localparam int CCEL_BIT_PIN_EN = 14;
  localparam int CCEL_BIT_INVERT = 13;
  localparam int CCEL_BIT_OPAMP = 10;
  localparam int CCEL_BIT_EVENT = 9;
  localparam int CCEL_BIT_RESULT = 8;
  localparam int CCEL_BIT_EDGE_HI = 7;
  localparam int CCEL_BIT_EDGE_LO = 6;
  localparam int CCEL_BIT_REF_SEL = 4;
  localparam int CCEL_BIT_CH_HI = 1;
  localparam int CCEL_BIT_CH_LO = 0;

  // Writable bits of the control word (result is read-only)
  localparam logic [15:0] CCEL_CTRL_WMASK = 16'hE6D3;
  localparam logic [15:0] CCEL_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CCEL_SHARED_STATUS_RESET = 16'h0000;

  // Shared status layout: event at bit 8, result at bit 0
  localparam int CCEL_STAT_EVENT_BIT = 8;
  localparam int CCEL_STAT_RESULT_BIT = 0;

  // Interrupt status / mask bits
  localparam int CCEL_IRQ_EVENT_BIT = 0;
  localparam int CCEL_IRQ_WIDTH = 1;

  typedef enum logic [1:0] {
    CCEL_EDGE_OFF,
    CCEL_EDGE_RISE,
    CCEL_EDGE_FALL,
    CCEL_EDGE_ANY
  } ccel_edge_t;
endpackage

// File: verilog/ccel_edge_detect.sv
// Edge detector: flags selected transitions of the polarity-adjusted result
`timescale 1ns/1ps
`default_nettype none
module ccel_edge_detect
  import ccel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic armed,
  input wire logic level,
  input wire logic [1:0] edge_sel,
  output logic hit
);
  logic prev;
  logic next_prev;
  logic rise;
  logic fall;

  always_comb begin
    // Disarmed history tracks the level so re-arming never sees a stale edge
    next_prev = level;
    rise = level & ~prev;
    fall = ~level & prev;
    case (ccel_edge_t'(edge_sel))
      CCEL_EDGE_ANY: hit = armed & (rise | fall); // RULE_08
      CCEL_EDGE_FALL: hit = armed & fall; // RULE_08
      CCEL_EDGE_RISE: hit = armed & rise; // RULE_08
      default: hit = 1'b0; // RULE_08
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end
endmodule
`default_nettype wire

// File: verilog/ccel_top.sv
// Comparator channel control, event logic and APB register slave
// Function
// RULE_01 - Pin-enable drives adjusted result onto pin
// RULE_02 - Invert select inverts result before use
// RULE_03 - Op amp enable bit switches op amp
// RULE_04 - Matching edge sets sticky event, blocks triggers
// RULE_05 - Result bit reads polarity-adjusted comparison
// RULE_06 - Op amp enable never stops comparator
// RULE_07 - Software clears event, flag before irq enable
// RULE_08 - Edge select: any, fall, rise, off
// RULE_09 - Shared status mirrors event and result
// RULE_10 - Comparator enable gates channel and events
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ccel_top
  import ccel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic analog_compare,
  output logic comparator_output_pin,
  output logic opamp_on,
  output logic comparator_on,
  output logic [1:0] neg_input_select,
  output logic pos_ref_select,
  output logic event_trigger,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic result;
  logic next_result;
  logic [CCEL_IRQ_WIDTH-1:0] irq_stat;
  logic [CCEL_IRQ_WIDTH-1:0] next_irq_stat;
  logic [CCEL_IRQ_WIDTH-1:0] irq_mask;
  logic [CCEL_IRQ_WIDTH-1:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_pin;
  logic next_trigger;
  logic next_irq;
  logic hit;
  logic wr_ctrl;
  logic rd_irq;
  logic access;
  logic known;

  function automatic logic [15:0] shared_status(input logic [15:0] c);
    logic [15:0] s;
    s = CCEL_SHARED_STATUS_RESET;
    s[CCEL_STAT_EVENT_BIT] = c[CCEL_BIT_EVENT]; // RULE_09
    s[CCEL_STAT_RESULT_BIT] = c[CCEL_BIT_RESULT]; // RULE_09
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  ccel_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .armed(ctrl[CCEL_BIT_ENABLE] & ~ctrl[CCEL_BIT_EVENT]), // RULE_04 RULE_10
    .level(result),
    .edge_sel(ctrl[CCEL_BIT_EDGE_HI:CCEL_BIT_EDGE_LO]),
    .hit(hit)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    access = psel & penable & ~pready;
    known = (paddr == CCEL_ADDR_CTRL) || (paddr == CCEL_ADDR_STAT)
      || (paddr == CCEL_ADDR_IRQ_STAT) || (paddr == CCEL_ADDR_IRQ_MASK);
    wr_ctrl = access & pwrite & (paddr == CCEL_ADDR_CTRL);
    rd_irq = access & ~pwrite & (paddr == CCEL_ADDR_IRQ_STAT);

    // Result is the inverted-or-not comparison; held low while disabled
    next_result = ctrl[CCEL_BIT_ENABLE]
      & (analog_compare ^ ctrl[CCEL_BIT_INVERT]); // RULE_02 RULE_05 RULE_10

    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = (ctrl & ~CCEL_CTRL_WMASK) | (pwdata[15:0] & CCEL_CTRL_WMASK);
    end
    next_ctrl[CCEL_BIT_RESULT] = result; // RULE_05
    // Set wins over a clearing write in the same cycle
    if (hit) begin
      next_ctrl[CCEL_BIT_EVENT] = 1'b1; // RULE_04
    end

    next_irq_stat = irq_stat;
    if (rd_irq) begin
      next_irq_stat = '0;
    end
    if (hit) begin
      next_irq_stat[CCEL_IRQ_EVENT_BIT] = 1'b1;
    end
    next_irq_mask = irq_mask;
    if (access & pwrite & (paddr == CCEL_ADDR_IRQ_MASK)) begin
      next_irq_mask = pwdata[CCEL_IRQ_WIDTH-1:0];
    end
    next_irq = |(next_irq_stat & next_irq_mask);

    next_pready = access;
    next_pslverr = access & ~known;
    next_prdata = 32'h0000_0000;
    if (access & ~pwrite) begin
      if (paddr == CCEL_ADDR_CTRL) begin
        next_prdata = {16'h0000, ctrl};
      end else if (paddr == CCEL_ADDR_STAT) begin
        next_prdata = {16'h0000, shared_status(ctrl)}; // RULE_09
      end else if (paddr == CCEL_ADDR_IRQ_STAT) begin
        next_prdata = {{(32-CCEL_IRQ_WIDTH){1'b0}}, irq_stat};
      end else if (paddr == CCEL_ADDR_IRQ_MASK) begin
        next_prdata = {{(32-CCEL_IRQ_WIDTH){1'b0}}, irq_mask};
      end
    end

    next_pin = ctrl[CCEL_BIT_PIN_EN] & result; // RULE_01
    // Trigger is a one-cycle pulse, suppressed while the event is pending
    next_trigger = hit; // RULE_04
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CCEL_CTRL_RESET;
      result <= 1'b0;
      irq_stat <= '0;
      irq_mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      comparator_output_pin <= 1'b0;
      opamp_on <= 1'b0;
      comparator_on <= 1'b0;
      neg_input_select <= 2'h0;
      pos_ref_select <= 1'b0;
      event_trigger <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      result <= next_result;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      comparator_output_pin <= next_pin; // RULE_01
      opamp_on <= next_ctrl[CCEL_BIT_OPAMP]; // RULE_03 RULE_06
      comparator_on <= next_ctrl[CCEL_BIT_ENABLE]; // RULE_06 RULE_10
      neg_input_select <= next_ctrl[CCEL_BIT_CH_HI:CCEL_BIT_CH_LO];
      pos_ref_select <= next_ctrl[CCEL_BIT_REF_SEL];
      event_trigger <= next_trigger;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire
